// >>> hdl/delay_counter.sv
module delay_counter #(
  parameter int W = 8
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic restart_i,
  input wire logic advance_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);

  logic [W-1:0] cnt_r;

  // Restart wins over advance so a re-entered delay always counts in full.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
    end else if (restart_i) begin
      cnt_r <= '0;
    end else if (advance_i && cnt_r != limit_i) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // The count saturates at the limit, so done stays up until a restart.
  assign done_o = (cnt_r == limit_i);

endmodule

// >>> hdl/parity_check.sv
`include "rts_defs.svh"

module parity_check (
  input wire logic [`WORD_W-1:0] word_i,
  input wire logic par_even_i,
  input wire logic par_odd_i,
  output logic error_o
);

  logic [`WORD_W/2-1:0] even_bits;
  logic [`WORD_W/2-1:0] odd_bits;

  // Split the word into alternating bit positions.
  for (genvar i = 0; i < `WORD_W / 2; i++) begin : g_split
    assign even_bits[i] = word_i[2*i];
    assign odd_bits[i] = word_i[2*i+1];
  end

  // Even bit folds in directly, the odd bit is negated first.
  assign error_o = (^even_bits ^ par_even_i) | (^odd_bits ^ ~par_odd_i);

endmodule

// >>> hdl/reset_timeout_sequencer.sv
// Our own choices: the register addresses and the strobed register port.
`include "rts_defs.svh"

module reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int RC_TICK_NS = 8,
  parameter int POWERUP_DELAY_TIMER_TICKS = (`POWERUP_DELAY_TIMER_TIME_MS * 1000000) / RC_TICK_NS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic por_pulse_i,
  input wire logic low_supply_i,
  input wire logic external_reset_pin_n_i,
  input wire logic osc_input_pin_i,
  input wire logic rc_tick_i,
  input wire logic sleeping_i,
  input wire logic watchdog_reset_i,
  input wire logic watchdog_wake_i,
  input wire logic irq_wake_i,
  input wire logic fetch_valid_i,
  input wire logic [`WORD_W-1:0] fetch_word_i,
  input wire logic fetch_par_even_i,
  input wire logic fetch_par_odd_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic core_reset_o,
  output logic core_stall_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);

  localparam logic [`POWERUP_DELAY_TIMER_CNT_W-1:0] POWERUP_DELAY_TIMER_LIMIT =
    `POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_TICKS - 1);
  localparam logic [`OST_CNT_W-1:0] OST_LIMIT =
    `OST_CNT_W'(`OST_CYCLES);

  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [7:0] cfg_r;
  logic [2:0] ps_r;
  logic por_seq_r;
  logic wake_seq_r;
  logic osc_q_r;
  logic osc_edge;
  logic powerup_delay_timer_done;
  logic ost_done;
  logic powerup_delay_timer_restart;
  logic ost_restart;
  logic par_err;
  logic par_hit;
  logic bor_en;
  logic powerup_delay_timer_en;
  logic par_en;
  logic crystal;
  logic wake_evt;
  logic hold_nxt;

  // Configuration word fields and the combined wake event.
  assign bor_en = cfg_r[`CFG_LOW_SUPPLY_EN_BIT];
  assign powerup_delay_timer_en = cfg_r[`CFG_POWERUP_DELAY_TIMER_EN_BIT];
  assign par_en = cfg_r[`CFG_PARITY_EN_BIT];
  assign crystal = (cfg_r[`CFG_OSC_LSB +: 2] != rc_osc_mode);
  assign wake_evt = watchdog_wake_i | irq_wake_i;

  // Oscillator edges drive the settle count; the pin is already in the
  // core clock domain, so one stage for the edge detector is enough.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_q_r <= 1'b0;
    end else begin
      osc_q_r <= osc_input_pin_i;
    end
  end
  assign osc_edge = osc_input_pin_i & ~osc_q_r;

  // Counters restart whenever their state is entered afresh.
  assign powerup_delay_timer_restart = (state_nxt == ST_POWERUP_DELAY_TIMER) && (state_r != ST_POWERUP_DELAY_TIMER);
  assign ost_restart = (state_nxt == ST_OST) && (state_r != ST_OST);

  // Power-up delay advances on the internal RC tick only.
  delay_counter #(
    .W(`POWERUP_DELAY_TIMER_CNT_W)
  ) u_powerup_delay_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .restart_i(powerup_delay_timer_restart),
    .advance_i(rc_tick_i && state_r == ST_POWERUP_DELAY_TIMER),
    .limit_i(POWERUP_DELAY_TIMER_LIMIT),
    .done_o(powerup_delay_timer_done)
  );

  // Settle timer counts oscillator rising edges.
  delay_counter #(
    .W(`OST_CNT_W)
  ) u_osc_settle_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .restart_i(ost_restart),
    .advance_i(osc_edge && state_r == ST_OST),
    .limit_i(OST_LIMIT),
    .done_o(ost_done)
  );

  // Parity of each executed word, gated by the configuration bit.
  parity_check u_parity_check (
    .word_i(fetch_word_i),
    .par_even_i(fetch_par_even_i),
    .par_odd_i(fetch_par_odd_i),
    .error_o(par_err)
  );
  assign par_hit = fetch_valid_i & par_en & par_err;

  // Next state: power-on beats low supply, which beats everything else.
  always_comb begin
    state_nxt = state_r;
    if (por_pulse_i) begin
      state_nxt = ST_POR;
    end else if (bor_en && low_supply_i) begin
      state_nxt = ST_BOR;
    end else begin
      case (state_r)
        ST_POR: begin
          if (powerup_delay_timer_en) begin
            state_nxt = ST_POWERUP_DELAY_TIMER;
          end else if (crystal) begin
            state_nxt = ST_OST;
          end else begin
            state_nxt = ST_RUN;
          end
        end
        ST_BOR: begin
          state_nxt = ST_POWERUP_DELAY_TIMER;
        end
        ST_POWERUP_DELAY_TIMER: begin
          if (powerup_delay_timer_done) begin
            state_nxt = (crystal && por_seq_r) ? ST_OST : ST_RUN;
          end
        end
        ST_OST: begin
          if (ost_done) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleeping_i && wake_evt && crystal) begin
            state_nxt = ST_OST;
          end
        end
        default: begin
          state_nxt = ST_POR;
        end
      endcase
    end
  end

  // Sequencer state register.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remember why the sequence started; the settle count is only due
  // after power-on or a wake from sleep.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_seq_r <= 1'b1;
      wake_seq_r <= 1'b0;
    end else if (state_nxt == ST_POR) begin
      por_seq_r <= 1'b1;
      wake_seq_r <= 1'b0;
    end else if (state_nxt == ST_BOR) begin
      por_seq_r <= 1'b0;
      wake_seq_r <= 1'b0;
    end else if (state_r == ST_RUN && state_nxt == ST_OST) begin
      por_seq_r <= 1'b0;
      wake_seq_r <= 1'b1;
    end else if (state_nxt == ST_RUN) begin
      wake_seq_r <= 1'b0;
    end
  end

  // The start-up delays run whatever the pin does; the pin only adds to
  // the hold, so a late release starts the core in the next cycle.
  assign hold_nxt = (state_nxt == ST_POR) || (state_nxt == ST_BOR) ||
                    (state_nxt == ST_POWERUP_DELAY_TIMER) ||
                    (state_nxt == ST_OST && !wake_seq_r &&
                     !(state_r == ST_RUN)) ||
                    !external_reset_pin_n_i || par_hit;

  // Outputs to the core are registered.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_reset_o <= 1'b1;
      core_stall_o <= 1'b0;
    end else begin
      core_reset_o <= hold_nxt;
      core_stall_o <= (state_nxt == ST_OST) && !hold_nxt;
    end
  end

  // Configuration word, writable so software can steer the sequencer.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= `CFG_RESET;
    end else if (wr_i && addr_i == `OFS_CONFIG) begin
      cfg_r <= wr_data_i;
    end
  end

  // Power status flags. A hardware clear or set in the same cycle as a
  // software write takes priority, so no reset cause is ever lost.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ps_r <= 3'h4;
    end else begin
      if (wr_i && addr_i == `OFS_POWER_STATUS) begin
        ps_r <= wr_data_i[2:0];
      end
      if (por_pulse_i) begin
        ps_r[`PS_POWERON_BIT] <= 1'b0;
        ps_r[`PS_PARITY_BIT] <= 1'b1;
      end else begin
        if (bor_en && low_supply_i) begin
          ps_r[`PS_LOW_SUPPLY_BIT] <= 1'b0;
        end
        if (par_hit) begin
          ps_r[`PS_PARITY_BIT] <= 1'b0;
        end
      end
    end
  end

  // Time-out and power-down flags record power-on, watchdog and wake events; low-supply, parity and awake pin resets leave them.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end else if (por_pulse_i) begin
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end else if (watchdog_reset_i) begin
      timeout_flag_o <= 1'b0;
      powerdown_flag_o <= 1'b1;
    end else if (watchdog_wake_i) begin
      timeout_flag_o <= 1'b0;
      powerdown_flag_o <= 1'b0;
    end else if (irq_wake_i ||
                 (sleeping_i && !external_reset_pin_n_i)) begin
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b0;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `OFS_POWER_STATUS) begin
        rd_data_o <= {par_en, 4'h0, ps_r};
      end else if (addr_i == `OFS_CONFIG) begin
        rd_data_o <= cfg_r;
      end else if (addr_i == `OFS_SEQ_STATUS) begin
        rd_data_o <= {1'b0, powerdown_flag_o, timeout_flag_o, state_r};
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  logic [`OST_CNT_W:0] ost_seen_r;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ost_seen_r <= '0;
    end else if (ost_restart) begin
      ost_seen_r <= '0;
    end else if (state_r == ST_OST && osc_edge) begin
      ost_seen_r <= ost_seen_r + (`OST_CNT_W+1)'(1);
    end
  end

  chk_ost_full_count: assert property (
    state_r == ST_OST && state_nxt == ST_RUN && !por_pulse_i
    |-> ost_seen_r == (`OST_CNT_W+1)'(`OST_CYCLES))
    else $error("settle count ended early");

  chk_ost_mode_gate: assert property (
    $rose(state_r == ST_OST) |-> $past(crystal))
    else $error("settle count in RC mode");

  chk_bor_disabled: assert property (
    !bor_en && !por_pulse_i |=> state_r != ST_BOR)
    else $error("low-supply reset while disabled");

  chk_bor_hold_then: assert property (
    state_r == ST_BOR && !low_supply_i && !por_pulse_i
    |=> state_r == ST_POWERUP_DELAY_TIMER && core_reset_o)
    else $error("no power-up delay after low supply");

  chk_powerup_delay_timer_restart: assert property (
    state_r == ST_POWERUP_DELAY_TIMER && bor_en && low_supply_i && !por_pulse_i
    |=> state_r == ST_BOR ##1 core_reset_o)
    else $error("low supply did not restart delay");

  chk_por_order: assert property (
    state_r == ST_POR && !por_pulse_i && powerup_delay_timer_en &&
    !(bor_en && low_supply_i) |=> state_r == ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay not after pulse");

  chk_rc_nodelay: assert property (
    state_r == ST_POR && !por_pulse_i && !powerup_delay_timer_en && !crystal &&
    !(bor_en && low_supply_i) |=> state_r == ST_RUN)
    else $error("start-up delay in RC mode");

  chk_pin_release: assert property (
    state_r == ST_RUN && external_reset_pin_n_i && !par_hit &&
    !por_pulse_i && !(bor_en && low_supply_i) |=> !core_reset_o)
    else $error("core held after pin release");

  chk_por_flags: assert property (
    por_pulse_i |=> !ps_r[`PS_POWERON_BIT] && ps_r[`PS_PARITY_BIT] &&
    timeout_flag_o && powerdown_flag_o && core_reset_o)
    else $error("power-on flags wrong");

  chk_parity_reset: assert property (
    par_hit && !por_pulse_i |=> core_reset_o)
    else $error("parity fault did not reset core");

  chk_wdt_flags: assert property (
    watchdog_reset_i && !por_pulse_i
    |=> !timeout_flag_o && powerdown_flag_o)
    else $error("watchdog reset flags wrong");

endmodule

// >>> hdl/rts_defs.svh
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH

// Clock and start-up timing.
`define CLK_PERIOD_NS 8
`define POWERUP_DELAY_TIMER_TIME_MS 72
`define OST_CYCLES 1024
`define POWERUP_DELAY_TIMER_CNT_W 24
`define OST_CNT_W 11

// Register offsets on the plain register port.
`define ADDR_W 4
`define OFS_POWER_STATUS 4'h0
`define OFS_CONFIG 4'h1
`define OFS_SEQ_STATUS 4'h2

// Power status field positions.
`define PS_LOW_SUPPLY_BIT 0
`define PS_POWERON_BIT 1
`define PS_PARITY_BIT 2
`define PS_PARITY_EN_BIT 7
`define PS_SW_MASK 8'h07

// Configuration word layout and reset value.
`define CFG_WORD_ADDR 14'h2007
`define CFG_PARITY_EN_BIT 7
`define CFG_LOW_SUPPLY_EN_BIT 6
`define CFG_POWERUP_DELAY_TIMER_EN_BIT 3
`define CFG_OSC_LSB 0
`define CFG_RESET 8'hC9

// Program word width.
`define WORD_W 14

`endif

// >>> hdl/rts_pkg.sv
package rts_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_POR  = 5'h01,
    ST_BOR  = 5'h02,
    ST_POWERUP_DELAY_TIMER = 5'h04,
    ST_OST  = 5'h08,
    ST_RUN  = 5'h10
  } seq_state_e;

  // Oscillator modes held in the configuration word.
  typedef enum logic [1:0] {
    crystal_lowpower_mode = 2'h0,
    crystal_std_mode      = 2'h1,
    crystal_fast_mode     = 2'h2,
    rc_osc_mode           = 2'h3
  } osc_mode_e;

endpackage

// >>> verif/supply_model.sv
module supply_model (
  input wire logic ref_clk_i,
  output logic osc_input_pin_o,
  output logic rc_tick_o,
  output logic por_pulse_o,
  output logic low_supply_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Power comes up with the on-chip pulse active and the supply good.
  initial begin
    osc_input_pin_o = 1'b0;
    rc_tick_o = 1'b1;
    por_pulse_o = 1'b1;
    low_supply_o = 1'b0;
  end

  // The crystal runs free, one rising edge every two core cycles.
  always @(posedge ref_clk_i) begin
    osc_input_pin_o <= ~osc_input_pin_o;
  end

  // Sets the pulse and detector levels; call it just after a rising edge.
  task automatic set(input logic p, input logic l);
    por_pulse_o <= p;
    low_supply_o <= l;
  endtask
endmodule

// >>> verif/test_reset_timeout_sequencer.sv
`include "rts_defs.svh"

module test_reset_timeout_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, pin_n, slp, wdr, wdw, irqw, fv, pe, po, wr, rd;
  logic osc, tick, por, low, crst, stall, tof, pdf;
  logic [`WORD_W-1:0] word;
  logic [`ADDR_W-1:0] addr;
  logic [7:0] wdat, rdat, q;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  supply_model model (.ref_clk_i(clk), .osc_input_pin_o(osc),
    .rc_tick_o(tick), .por_pulse_o(por), .low_supply_o(low));

  // A short delay count keeps the power-up walk to a few thousand cycles.
  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_TICKS(20)) dut (
    .ref_clk_i(clk), .nrst_i(nrst), .por_pulse_i(por),
    .low_supply_i(low), .external_reset_pin_n_i(pin_n),
    .osc_input_pin_i(osc), .rc_tick_i(tick), .sleeping_i(slp),
    .watchdog_reset_i(wdr), .watchdog_wake_i(wdw), .irq_wake_i(irqw),
    .fetch_valid_i(fv), .fetch_word_i(word), .fetch_par_even_i(pe),
    .fetch_par_odd_i(po), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .core_reset_o(crst),
    .core_stall_o(stall), .timeout_flag_o(tof), .powerdown_flag_o(pdf));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang ends the run as a failure instead of spinning forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic chk(input string s, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read, so sample there.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdat;
  endtask

  task automatic wait_rel(output int k);
    k = 0;
    while (crst !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk("release", crst, 1'b0);
  endtask

  // Pulses one wake or reset event, then checks both cause flags.
  task automatic ev(input int k, input logic t, p);
    @(posedge clk);
    {wdr, wdw, irqw} <= 3'b100 >> k;
    @(posedge clk);
    {wdr, wdw, irqw} <= 3'b000;
    repeat (3) @(posedge clk);
    chk("timeout_flag", tof, t);
    chk("powerdown_flag", pdf, p);
  endtask

  // Bad bits flip the even or odd parity bit of an otherwise good word.
  task automatic fetch(input logic [13:0] w, input logic [1:0] bad,
                       input logic exp_rst);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    fv <= 1'b1;
    word <= w;
    pe <= ^(w & 14'h1555) ^ bad[0];
    po <= ~^(w & 14'h2AAA) ^ bad[1];
    @(posedge clk);
    fv <= 1'b0;
    repeat (3) begin
      @(negedge clk);
      if (crst === 1'b1) seen = 1'b1;
    end
    chk("parity_reset", seen, exp_rst);
  endtask

  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {nrst, pin_n, slp, wdr, wdw, irqw, fv, pe, po, wr, rd} = '0;
    word = '0;
    addr = '0;
    wdat = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    // Power-up with the reset pin held low all the way through.
    model.set(1'b0, 1'b0);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_reset", q, 8'h84);
    repeat (2030) @(posedge clk);
    rd_reg(`OFS_SEQ_STATUS);
    chk("seq_settle", q, 8'h68);
    repeat (250) @(posedge clk);
    rd_reg(`OFS_SEQ_STATUS);
    chk("seq_run", q, 8'h70);
    chk("held_by_pin", crst, 1'b1);
    @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("pin_release", crst, 1'b0);
    chk("por_flags", {tof, pdf}, 2'b11);
    wr_reg(`OFS_POWER_STATUS, 8'h07);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_sw_set", q, 8'h87);
    rd_reg(4'hF);
    chk("unmapped", q, 8'h00);
    // Reset causes and the combined reset output.
    ev(0, 1'b0, 1'b1);
    wait_rel(n);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (3) @(negedge clk);
    chk("pin_reset", crst, 1'b1);
    chk("pin_flags", {tof, pdf}, 2'b01);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_rel(n);
    slp <= 1'b1;
    ev(2, 1'b1, 1'b0);
    ev(1, 1'b0, 1'b0);
    slp <= 1'b0;
    repeat (2100) @(posedge clk);
    // Low supply, returning once while the delay counts.
    model.set(1'b0, 1'b1);
    repeat (5) @(posedge clk);
    chk("low_hold", crst, 1'b1);
    model.set(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    model.set(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    model.set(1'b0, 1'b0);
    wait_rel(n);
    chk("low_delay", n >= 20 && n < 40, 1'b1);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_low", q, 8'h86);
    // Program word parity.
    fetch(14'h1234, 2'b00, 1'b0);
    fetch(14'h1234, 2'b01, 1'b1);
    fetch(14'h2BCD, 2'b10, 1'b1);
    wait_rel(n);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_parity", q, 8'h82);
    // Low-supply reset and parity disabled; delay stays enabled.
    wr_reg(`OFS_CONFIG, 8'h09);
    fetch(14'h1234, 2'b01, 1'b0);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_par_off", q, 8'h02);
    @(posedge clk);
    model.set(1'b0, 1'b1);
    repeat (5) @(posedge clk);
    chk("low_ignored", crst, 1'b0);
    model.set(1'b0, 1'b0);
    // RC mode with the delay disabled starts at once after power-on.
    wr_reg(`OFS_CONFIG, 8'h03);
    model.set(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    model.set(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk("rc_no_delay", crst, 1'b0);
    chk("rc_flags", {tof, pdf}, 2'b11);
    rd_reg(`OFS_POWER_STATUS);
    chk("ps_por", q & 8'hFE, 8'h04);
    results();
  end
endmodule
